// ### logic/rhc_pkg.sv
// Shared constants and types for the heating relay channel controller
package rhc_pkg;
	// Channel and address widths
	localparam int NCH = 4;
	localparam int ADDR_W = 24;
	localparam int MIN_W = 10;
	localparam int PIDLE_W = 5;
	localparam int DUTY_W = 4;
	// Bus register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [3:0] REG_LINK_PAGE = 4'h1;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	// Control register bits
	localparam int CTRL_TS12 = 0;
	localparam int CTRL_TS34 = 1;
	localparam int CTRL_MS = 2;
	localparam int CTRL_COOL = 3;
	localparam int CTRL_ERASE = 4;
	// Status register fields
	localparam int ST_RELAY_LSB = 0;
	localparam int ST_LAMP_LSB = 4;
	localparam int ST_LOST_LSB = 8;
	localparam int ST_PUMP_EN = 12;
	localparam int ST_COOL = 13;
	localparam int ST_TONE = 14;
	localparam int ST_PUMP_STOP = 15;
	// Link entry register bits
	localparam int LNK_VALID = 31;
	localparam int LNK_SLAVE = 30;
	// Timing: clock, second and minute scale figures
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned SEC_NS = 1_000_000_000;
	localparam int unsigned SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
	localparam logic [5:0] MIN_SEC = 6'h3C;
	localparam logic [PIDLE_W-1:0] PUMP_IDLE_MIN = 5'h0A;
	localparam logic [DUTY_W-1:0] DUTY_ON_MIN = 4'h3;
	localparam logic [DUTY_W-1:0] DUTY_OFF_MIN = 4'h7;
	localparam logic [DUTY_W-1:0] DUTY_PERIOD = DUTY_ON_MIN + DUTY_OFF_MIN;
	localparam logic [MIN_W-1:0] LOSS_MIN = 10'h03C;
	localparam logic [MIN_W-1:0] LONG_LOSS_MIN = 10'h258;
	localparam logic [MIN_W-1:0] IDLE_MAX = 10'h3FF;
	// Decoded radio message from a thermostat transmitter
	typedef struct packed {
		logic [ADDR_W-1:0] src;
		logic heat;
		logic setback;
		logic warmup;
		logic auto_mode;
	} rhc_msg_s;
	// One learned link entry
	typedef struct packed {
		logic valid;
		logic slave;
		logic [ADDR_W-1:0] addr;
	} rhc_link_s;
endpackage : rhc_pkg

// ### logic/rhc_timebase.sv
// Free-running second and minute timebase
`timescale 1ns/10ps
module rhc_timebase #(
	parameter int unsigned SEC_CYC = rhc_pkg::SEC_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	output logic sec_tick,
	output logic min_tick,
	output logic blink
);
	import rhc_pkg::*;
	typedef struct packed {
		logic [31:0] cyc;
		logic [5:0] sec;
		logic blink;
	} rhc_tb_s;
	rhc_tb_s st_r;
	rhc_tb_s st_nxt;
	// Cycle and second dividers
	always_comb begin
		st_nxt = st_r;
		sec_tick = (st_r.cyc == SEC_CYC - 1);
		min_tick = sec_tick && (st_r.sec == MIN_SEC - 6'h01);
		blink = st_r.blink;
		st_nxt.cyc = sec_tick ? 32'h0 : st_r.cyc + 32'h1;
		if (sec_tick) begin
			st_nxt.sec = min_tick ? 6'h00 : st_r.sec + 6'h01;
			st_nxt.blink = ~st_r.blink;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	property p_sec_range;
		@(posedge hclk) disable iff (!hresetn) st_r.sec < MIN_SEC;
	endproperty
	a_sec_range: assert property (p_sec_range) else $error("second counter out of range");
	property p_min_spacing;
		@(posedge hclk) disable iff (!hresetn) min_tick |=> !min_tick;
	endproperty
	a_min_spacing: assert property (p_min_spacing) else $error("minute tick repeated");
endmodule : rhc_timebase

// ### logic/rhc_link_table.sv
// Learned transmitter address table with registered read port
`timescale 1ns/10ps
module rhc_link_table (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic we,
	input wire logic [1:0] widx,
	input wire logic [31:0] wdata,
	input wire logic erase,
	input wire logic [1:0] ridx,
	output logic [31:0] rdata,
	input wire logic [rhc_pkg::ADDR_W-1:0] src,
	output logic [rhc_pkg::NCH-1:0] valid,
	output logic [rhc_pkg::NCH-1:0] slave,
	output logic [rhc_pkg::NCH-1:0] match
);
	import rhc_pkg::*;
	typedef struct packed {
		rhc_link_s [NCH-1:0] ent;
		logic [31:0] rdata;
	} rhc_lt_s;
	rhc_lt_s st_r;
	rhc_lt_s st_nxt;
	// Address compare, one per entry
	for (genvar i = 0; i < NCH; i++) begin : g_ent
		assign valid[i] = st_r.ent[i].valid;
		assign slave[i] = st_r.ent[i].slave;
		assign match[i] = st_r.ent[i].valid && (st_r.ent[i].addr == src);
	end
	// Write, erase and read register
	always_comb begin
		st_nxt = st_r;
		st_nxt.rdata = {st_r.ent[ridx].valid, st_r.ent[ridx].slave, 6'h00, st_r.ent[ridx].addr};
		if (we) begin
			st_nxt.ent[widx] = {wdata[LNK_VALID], wdata[LNK_SLAVE], wdata[ADDR_W-1:0]};
		end
		if (erase) begin
			st_nxt.ent = '0;
		end
		rdata = st_r.rdata;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule : rhc_link_table

// ### logic/rhc_top.sv
// Four-channel heating relay controller with AHB-Lite register access
//
// Added by the designer: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps
module rhc_top #(
	parameter int unsigned SEC_CYC = rhc_pkg::SEC_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic msg_valid,
	input wire rhc_pkg::rhc_msg_s msg,
	input wire logic [rhc_pkg::NCH-1:0] btn_ch,
	input wire logic btn_reset,
	output logic [rhc_pkg::NCH-1:0] relay,
	output logic [rhc_pkg::NCH-1:0] lamp,
	output logic tone
);
	import rhc_pkg::*;
	typedef struct packed {
		logic ap_rd;
		logic ap_wr;
		logic [7:0] ap_addr;
		logic rd_done;
		logic [31:0] hrdata;
		logic ts12;
		logic ts34;
		logic ms_en;
		logic cool;
		logic pump_en;
		logic rbtn_q;
		logic [NCH-1:0] heat;
		logic [NCH-1:0] setback;
		logic [NCH-1:0] warm;
		logic [NCH-1:0] auto_mode;
		logic [NCH-1:0][MIN_W-1:0] idle;
		logic [PIDLE_W-1:0] pump_idle;
		logic [DUTY_W-1:0] duty;
		logic [NCH-1:0] relay;
		logic [NCH-1:0] lamp;
		logic tone;
	} rhc_top_s;
	rhc_top_s st_r;
	rhc_top_s st_nxt;
	logic sec_tick;
	logic min_tick;
	logic blink;
	logic lt_we;
	logic lt_erase;
	logic [31:0] lt_rdata;
	logic [NCH-1:0] lk_valid;
	logic [NCH-1:0] lk_slave;
	logic [NCH-1:0] lk_match;
	logic [NCH-1:0] lost;
	logic [NCH-1:0] lost_long;
	logic [NCH-1:0] demand;
	logic [NCH-1:0] tsw;
	logic [NCH-1:0] relay_val;
	logic [NCH-1:0] lamp_val;
	logic duty_on;
	logic pump_stop;
	logic mst_setback;
	logic mst_ok;
	logic link_page;
	logic rbtn_rel;
	logic erase_req;
	logic [31:0] ctrl_word;
	logic [31:0] stat_word;

	rhc_timebase #(
		.SEC_CYC(SEC_CYC)
	) u_tb (
		.hclk(hclk),
		.hresetn(hresetn),
		.sec_tick(sec_tick),
		.min_tick(min_tick),
		.blink(blink)
	);

	rhc_link_table u_lt (
		.hclk(hclk),
		.hresetn(hresetn),
		.we(lt_we),
		.widx(st_r.ap_addr[3:2]),
		.wdata(hwdata),
		.erase(lt_erase),
		.ridx(haddr[3:2]),
		.rdata(lt_rdata),
		.src(msg.src),
		.valid(lk_valid),
		.slave(lk_slave),
		.match(lk_match)
	);

	// Bus response and register decode
	assign hreadyout = !(st_r.ap_rd && !st_r.rd_done);
	assign hresp = 1'b0;
	assign hrdata = st_r.hrdata;
	assign link_page = (st_r.ap_addr[7:4] == REG_LINK_PAGE);
	assign lt_we = st_r.ap_wr && link_page;
	assign rbtn_rel = st_r.rbtn_q && !btn_reset;
	assign erase_req = (st_r.ap_wr && st_r.ap_addr == REG_CTRL && hwdata[CTRL_ERASE]) || (rbtn_rel && btn_ch[0]);
	assign lt_erase = erase_req;
	assign ctrl_word = {27'h0, 1'b0, st_r.cool, st_r.ms_en, st_r.ts34, st_r.ts12};
	assign stat_word = {16'h0, pump_stop, st_r.tone, st_r.cool, st_r.pump_en, lost, st_r.lamp, st_r.relay};

	// Fallback duty and master status
	assign duty_on = (st_r.duty < DUTY_ON_MIN);
	assign pump_stop = (st_r.pump_idle > PUMP_IDLE_MIN);
	assign mst_ok = lk_valid[0] && !lost[0];
	assign mst_setback = st_r.setback[0] && !st_r.warm[0];

	// Per-channel demand, fallback and output selection
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		logic own;
		logic follow;
		logic is_ts;
		logic is_pump;
		assign lost[i] = lk_valid[i] && (st_r.idle[i] >= LOSS_MIN);
		assign lost_long[i] = lk_valid[i] && (st_r.idle[i] >= LONG_LOSS_MIN);
		assign own = lost[i] ? duty_on : st_r.heat[i];
		assign follow = (i != 0) && st_r.ms_en && lk_slave[i] && st_r.auto_mode[i] && mst_ok;
		assign demand[i] = lk_valid[i] && (follow ? (own && !mst_setback) : own);
		assign tsw[i] = st_r.setback[i] && !st_r.warm[i];
		assign is_ts = ((i == 1) && st_r.ts12) || ((i == 3) && st_r.ts34);
		assign is_pump = (i == 3) && st_r.pump_en && !st_r.ts34;
		always_comb begin
			if (is_ts) begin
				relay_val[i] = tsw[(i == 0) ? 0 : i - 1];
				lamp_val[i] = relay_val[i];
			end else if (is_pump) begin
				relay_val[i] = pump_stop;
				lamp_val[i] = !pump_stop;
			end else begin
				relay_val[i] = lk_valid[i] && (demand[i] ^ st_r.cool);
				lamp_val[i] = lost[i] ? blink : relay_val[i];
			end
		end
	end

	// Next-state logic for bus, configuration and channel state
	always_comb begin
		st_nxt = st_r;
		// Address phase capture
		st_nxt.rd_done = st_r.ap_rd && !st_r.rd_done;
		if (hready) begin
			st_nxt.ap_rd = hsel && (htrans == HTRANS_NONSEQ) && !hwrite;
			st_nxt.ap_wr = hsel && (htrans == HTRANS_NONSEQ) && hwrite;
			st_nxt.ap_addr = haddr[7:0];
		end
		// Read data, loaded in the wait cycle
		if (st_r.ap_rd && !st_r.rd_done) begin
			if (st_r.ap_addr == REG_CTRL) begin
				st_nxt.hrdata = ctrl_word;
			end else if (st_r.ap_addr == REG_STATUS) begin
				st_nxt.hrdata = stat_word;
			end else if (link_page && st_r.ap_addr[1:0] == 2'h0) begin
				st_nxt.hrdata = lt_rdata;
			end else begin
				st_nxt.hrdata = 32'h0;
			end
		end
		// Control register write
		if (st_r.ap_wr && st_r.ap_addr == REG_CTRL) begin
			st_nxt.ts12 = hwdata[CTRL_TS12];
			st_nxt.ts34 = hwdata[CTRL_TS34];
			st_nxt.ms_en = hwdata[CTRL_MS];
			st_nxt.cool = hwdata[CTRL_COOL];
		end
		// Learning channel four disables pump logic
		if (lt_we && st_r.ap_addr[3:2] == 2'h3 && hwdata[LNK_VALID]) begin
			st_nxt.pump_en = 1'b0;
		end
		// Buttons sampled at release of the reset button
		st_nxt.rbtn_q = btn_reset;
		if (rbtn_rel && btn_ch[2]) begin
			st_nxt.cool = 1'b1;
		end else if (rbtn_rel && btn_ch[3]) begin
			st_nxt.cool = 1'b0;
		end
		// Message intake and silence counters
		for (int i = 0; i < NCH; i++) begin
			if (msg_valid && lk_match[i]) begin
				st_nxt.heat[i] = msg.heat;
				st_nxt.setback[i] = msg.setback;
				st_nxt.warm[i] = msg.warmup;
				st_nxt.auto_mode[i] = msg.auto_mode;
				st_nxt.idle[i] = '0;
			end else if (min_tick && st_r.idle[i] != IDLE_MAX) begin
				st_nxt.idle[i] = st_r.idle[i] + 10'h001;
			end
		end
		// Duty cycle minute counter
		if (min_tick) begin
			st_nxt.duty = (st_r.duty == DUTY_PERIOD - 4'h1) ? 4'h0 : st_r.duty + 4'h1;
		end
		// Pump idle minutes since last heat demand
		if (|demand[NCH-2:0]) begin
			st_nxt.pump_idle = '0;
		end else if (min_tick && !pump_stop) begin
			st_nxt.pump_idle = st_r.pump_idle + 5'h01;
		end
		// Erasing all links clears channel state and re-arms pump logic
		if (erase_req) begin
			st_nxt.pump_en = 1'b1;
			st_nxt.heat = '0;
			st_nxt.setback = '0;
			st_nxt.warm = '0;
			st_nxt.auto_mode = '0;
			st_nxt.idle = '0;
		end
		// Registered outputs
		st_nxt.relay = relay_val;
		st_nxt.lamp = lamp_val;
		st_nxt.tone = |lost_long;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= '0;
			st_r.pump_en <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign relay = st_r.relay;
	assign lamp = st_r.lamp;
	assign tone = st_r.tone;

	// Checks on channel behaviour
	property p_addr_filter;
		@(posedge hclk) disable iff (!hresetn)
		msg_valid && !(|lk_match) && !erase_req |=> $stable(st_r.heat);
	endproperty
	a_addr_filter: assert property (p_addr_filter) else $error("unmatched message changed state");
	property p_switch;
		@(posedge hclk) disable iff (!hresetn)
		msg_valid && lk_match[0] && msg.heat && !st_r.cool && !erase_req ##1 !lost[0] && !st_r.cool |=> relay[0];
	endproperty
	a_switch: assert property (p_switch) else $error("channel one relay did not follow heat");
	property p_pump_off;
		@(posedge hclk) disable iff (!hresetn)
		st_r.pump_en && !st_r.ts34 && pump_stop |=> relay[3] && !lamp[3];
	endproperty
	a_pump_off: assert property (p_pump_off) else $error("pump not stopped after idle time");
	property p_pump_disable;
		@(posedge hclk) disable iff (!hresetn)
		lt_we && st_r.ap_addr[3:2] == 2'h3 && hwdata[LNK_VALID] && !erase_req |=> !st_r.pump_en;
	endproperty
	a_pump_disable: assert property (p_pump_disable) else $error("pump logic kept after channel four learned");
	property p_pump_reenable;
		@(posedge hclk) disable iff (!hresetn)
		!st_r.pump_en && !erase_req |=> !st_r.pump_en;
	endproperty
	a_pump_reenable: assert property (p_pump_reenable) else $error("pump logic re-enabled without erase");
	property p_timeswitch;
		@(posedge hclk) disable iff (!hresetn)
		st_r.ts12 && st_r.setback[0] && !st_r.warm[0] |=> relay[1];
	endproperty
	a_timeswitch: assert property (p_timeswitch) else $error("time-switch output not on in setback");
	property p_heat_select;
		@(posedge hclk) disable iff (!hresetn)
		rbtn_rel && btn_ch[3] && !btn_ch[2] |=> !st_r.cool;
	endproperty
	a_heat_select: assert property (p_heat_select) else $error("heating mode not selected");
	property p_duty;
		@(posedge hclk) disable iff (!hresetn)
		st_r.duty < DUTY_PERIOD;
	endproperty
	a_duty: assert property (p_duty) else $error("duty counter out of range");
	// Checks on cooling, master/slave and fallback
	property p_cool_invert;
		@(posedge hclk) disable iff (!hresetn)
		lk_valid[0] && !lost[0] && st_r.cool |=> relay[0] != $past(st_r.heat[0]);
	endproperty
	a_cool_invert: assert property (p_cool_invert) else $error("cooling did not invert channel one");
	property p_pump_cool;
		@(posedge hclk) disable iff (!hresetn)
		st_r.cool && st_r.pump_en && !st_r.ts34 |=> relay[3] == $past(pump_stop);
	endproperty
	a_pump_cool: assert property (p_pump_cool) else $error("pump output inverted in cooling");
	property p_ts_cool;
		@(posedge hclk) disable iff (!hresetn)
		st_r.ts12 && st_r.cool |=> relay[1] == $past(st_r.setback[0] && !st_r.warm[0]);
	endproperty
	a_ts_cool: assert property (p_ts_cool) else $error("time-switch output inverted in cooling");
	property p_slave_follow;
		@(posedge hclk) disable iff (!hresetn)
		st_r.ms_en && lk_valid[1] && lk_slave[1] && st_r.auto_mode[1] && mst_ok && mst_setback
		&& !st_r.ts12 && !st_r.cool |=> !relay[1];
	endproperty
	a_slave_follow: assert property (p_slave_follow) else $error("slave did not follow master setback");
	property p_master_lost;
		@(posedge hclk) disable iff (!hresetn)
		st_r.ms_en && lk_valid[1] && !lost[1] && !mst_ok && st_r.heat[1]
		&& !st_r.ts12 && !st_r.cool |=> relay[1];
	endproperty
	a_master_lost: assert property (p_master_lost) else $error("slave ignored own demand without master");
	property p_nonslave;
		@(posedge hclk) disable iff (!hresetn)
		lk_valid[1] && !lk_slave[1] && !lost[1] && st_r.heat[1] && !st_r.ts12 && !st_r.cool |=> relay[1];
	endproperty
	a_nonslave: assert property (p_nonslave) else $error("non-slave channel followed master");
	property p_fallback;
		@(posedge hclk) disable iff (!hresetn)
		lost[0] && !st_r.cool |=> relay[0] == $past(st_r.duty < DUTY_ON_MIN);
	endproperty
	a_fallback: assert property (p_fallback) else $error("lost channel not on fallback duty");
	property p_lost_lamp;
		@(posedge hclk) disable iff (!hresetn)
		lost[0] |=> lamp[0] == $past(blink);
	endproperty
	a_lost_lamp: assert property (p_lost_lamp) else $error("lost channel lamp not flashing");
	property p_tone;
		@(posedge hclk) disable iff (!hresetn)
		|lost_long |=> tone;
	endproperty
	a_tone: assert property (p_tone) else $error("tone silent during long loss");
	property p_pump_run;
		@(posedge hclk) disable iff (!hresetn)
		st_r.pump_en && !st_r.ts34 && !pump_stop |=> !relay[3] && lamp[3];
	endproperty
	a_pump_run: assert property (p_pump_run) else $error("pump not running while demanded");
endmodule : rhc_top

// ### sim/rhc_tx_model.sv
// Room thermostat transmitter model feeding decoded messages
`timescale 1ns/10ps
module rhc_tx_model (
	input wire logic hclk,
	output logic msg_valid,
	output rhc_pkg::rhc_msg_s msg
);
	import rhc_pkg::*;

	// Idle between messages
	initial begin
		msg_valid = 1'b0;
		msg = '0;
	end

	// One message for one cycle, then the fields turn to garbage
	task automatic send(input logic [23:0] a, input logic h, input logic s, input logic w, input logic au);
		msg_valid <= 1'b1;
		msg <= {a, h, s, w, au};
		@(posedge hclk);
		msg_valid <= 1'b0;
		msg <= ~{a, h, s, w, au}; // Stale fields look wrong
	endtask : send
endmodule : rhc_tx_model

// ### sim/test_rhc_top.sv
// Self-checking bench for the heating relay controller
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module test_rhc_top;
	import rhc_pkg::*;
	localparam int unsigned SC = 4;
	localparam int MINC = 60 * SC;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic msg_valid;
	rhc_msg_s msg;
	logic [3:0] btn_ch = 4'h0;
	logic btn_reset = 1'b0;
	logic [3:0] relay;
	logic [3:0] lamp;
	logic tone;
	logic [31:0] rd;
	logic [31:0] rd_q;
	int n_fail = 0;
	int n_compared = 0;
	int heat[4];
	int cool = 0;
	logic [23:0] addr[4];
	int nh = 0;
	int nl = 0;

	// Clock of 10 ns
	always #5 hclk = ~hclk;

	rhc_top #(.SEC_CYC(SC)) rhc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .msg_valid(msg_valid), .msg(msg),
		.btn_ch(btn_ch), .btn_reset(btn_reset), .relay(relay), .lamp(lamp), .tone(tone));
	rhc_tx_model rhc_tx_model_inst (.hclk(hclk), .msg_valid(msg_valid), .msg(msg));

	task automatic summarize();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : summarize

	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask : cyc

	// Bounded wait for hready high at a rising edge
	task automatic wait_ready();
		int k;
		for (k = 0; k < 20; k++) begin
			@(negedge hclk);
			if (hreadyout === 1'b1) break;
		end
		if (k == 20) begin
			n_fail++;
			$display("BAD hready exp 1 got 0");
			summarize();
		end
		rd_q = hrdata;
		@(posedge hclk);
	endtask : wait_ready

	// One single word transfer, address phase then data phase
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		r = rd_q;
	endtask : ahb

	task automatic rx(input int ch, input logic h, input logic s, input logic w);
		heat[ch] = h;
		rhc_tx_model_inst.send(addr[ch], h, s, w, 1'b1);
		cyc(2);
	endtask : rx

	// Expected relays of switching channels one to three
	task automatic chk_sw(input string nm);
		for (int i = 0; i < 3; i++) begin
			`CHK(nm, 1'(heat[i] ^ cool), relay[i])
		end
	endtask : chk_sw

	// Channel button held with reset, reset let go first
	task automatic press(input logic [3:0] m);
		btn_ch <= m;
		btn_reset <= 1'b1;
		cyc(3);
		btn_reset <= 1'b0;
		cyc(3);
		btn_ch <= 4'h0;
		cyc(3);
	endtask : press

	// Main sequence
	initial begin
		void'($urandom(32'hE30DAC8E));
		cyc(5);
		hresetn <= 1'b1;
		cyc(1);
		ahb(1'b0, {24'h0, REG_STATUS}, '0, rd);
		`CHK("pump_en", 1'b1, rd[ST_PUMP_EN])
		`CHK("cool", 1'b0, rd[ST_COOL])
		`CHK("hresp", 1'b0, hresp)
		ahb(1'b0, 32'h8, '0, rd);
		`CHK("unmapped", 32'h0, rd)
		$display("test reset done");
		for (int i = 0; i < 3; i++) begin
			addr[i] = 24'($urandom);
			heat[i] = 0;
			ahb(1'b1, 32'h10 + 4 * i, {8'h80, addr[i]}, rd);
		end
		for (int i = 0; i < 3; i++) rx(i, 1'($urandom), 1'b0, 1'b0);
		chk_sw("relay_sw");
		heat[0] = heat[0] ^ 1;
		rhc_tx_model_inst.send(~addr[0], 1'(heat[0]), 1'b0, 1'b0, 1'b1);
		heat[0] = heat[0] ^ 1;
		cyc(2);
		chk_sw("relay_foreign");
		$display("test switching done");
		rx(0, 1'b1, 1'b0, 1'b0);
		rx(1, 1'b0, 1'b0, 1'b0);
		rx(2, 1'b0, 1'b0, 1'b0);
		`CHK("pump_run", 2'b01, {relay[3], lamp[3]})
		rx(0, 1'b0, 1'b0, 1'b0);
		cyc(9 * MINC);
		`CHK("pump_9min", 2'b01, {relay[3], lamp[3]})
		cyc(4 * MINC);
		`CHK("pump_13min", 2'b10, {relay[3], lamp[3]})
		$display("test pump done");
		rx(0, 1'b1, 1'b0, 1'b0);
		rx(2, 1'b1, 1'b0, 1'b0);
		press(4'h4);
		cool = 1;
		chk_sw("relay_cool");
		`CHK("pump_cool", 1'b0, relay[3])
		ahb(1'b0, {24'h0, REG_STATUS}, '0, rd);
		`CHK("st_cool", 1'b1, rd[ST_COOL])
		press(4'h8);
		cool = 0;
		chk_sw("relay_heat");
		$display("test cooling done");
		ahb(1'b1, {24'h0, REG_CTRL}, 32'h1, rd);
		for (int k = 0; k < 4; k++) begin
			rx(0, 1'b1, k[0], k[1]);
			`CHK("ts_out", k[0] & ~k[1], relay[1])
			`CHK("ts_sw", 1'b1, relay[0])
		end
		ahb(1'b1, {24'h0, REG_CTRL}, 32'h0, rd);
		$display("test time switch done");
		addr[3] = 24'($urandom);
		ahb(1'b1, 32'h1C, {8'h80, addr[3]}, rd);
		ahb(1'b0, {24'h0, REG_STATUS}, '0, rd);
		`CHK("pump_off", 1'b0, rd[ST_PUMP_EN])
		rx(3, 1'b1, 1'b0, 1'b0);
		`CHK("ch4_sw", 1'b1, relay[3])
		press(4'h2);
		ahb(1'b0, {24'h0, REG_STATUS}, '0, rd);
		`CHK("pump_still_off", 1'b0, rd[ST_PUMP_EN])
		ahb(1'b1, {24'h0, REG_CTRL}, 32'h10, rd);
		ahb(1'b0, {24'h0, REG_STATUS}, '0, rd);
		`CHK("pump_back", 1'b1, rd[ST_PUMP_EN])
		ahb(1'b0, 32'h10, '0, rd);
		`CHK("link_erased", 1'b0, rd[LNK_VALID])
		$display("test erase done");
		// Master on channel one, slave on two, plain transmitter on three
		for (int i = 0; i < 3; i++) begin
			addr[i] = 24'($urandom);
			ahb(1'b1, 32'h10 + 4 * i, {1'b1, 1'(i == 1), 6'h00, addr[i]}, rd);
		end
		ahb(1'b1, {24'h0, REG_CTRL}, 32'h4, rd);
		rx(0, 1'b0, 1'b1, 1'b0);
		rx(1, 1'b1, 1'b0, 1'b0);
		rx(2, 1'b1, 1'b0, 1'b0);
		`CHK("slave_setback", 2'b10, {relay[2], relay[1]})
		rhc_tx_model_inst.send(addr[1], 1'b1, 1'b0, 1'b0, 1'b0);
		cyc(2);
		`CHK("slave_manual", 1'b1, relay[1])
		rx(1, 1'b1, 1'b0, 1'b0);
		rx(0, 1'b0, 1'b1, 1'b1);
		`CHK("slave_warmup", 1'b1, relay[1])
		rx(0, 1'b0, 1'b1, 1'b0);
		`CHK("slave_follow", 1'b0, relay[1])
		$display("test master slave done");
		// Master falls silent while the others keep reporting
		repeat (62) begin
			cyc(MINC);
			rx(1, 1'b1, 1'b0, 1'b0);
			rx(2, 1'b1, 1'b0, 1'b0);
		end
		ahb(1'b0, {24'h0, REG_STATUS}, '0, rd);
		`CHK("lost", 4'h1, rd[ST_LOST_LSB +: 4])
		`CHK("master_lost", 1'b1, relay[1])
		// One full fallback period: 3 of 10 minutes on, lamp blinking
		repeat (10 * MINC) begin
			@(negedge hclk);
			nh += relay[0];
			nl += lamp[0];
		end
		`CHK("fallback_on", 3 * MINC, nh)
		`CHK("fallback_lamp", 5 * MINC, nl)
		`CHK("tone_short_loss", 1'b0, tone)
		$display("test fallback done");
		press(4'h1);
		ahb(1'b0, 32'h14, '0, rd);
		`CHK("btn_erase", 1'b0, rd[LNK_VALID])
		`CHK("erase_relays", 3'h0, relay[2:0])
		$display("test button erase done");
		summarize();
	end
endmodule : test_rhc_top
